// File: hdl/hbridge_spi_pkg.sv
/*
  Constants shared by the H-bridge serial control and diagnosis port.
  Assumes nothing of its surroundings.
*/
package hbridge_spi_pkg;
  // ----------------------------------------------------------------
  // Command patterns (upper three bits of the command byte)
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_READ_FAULTS = 3'h0;
  localparam logic [2:0] CMD_READ_VERSION = 3'h1;
  localparam logic [2:0] CMD_READ_SETTINGS = 3'h3;
  localparam logic [2:0] CMD_CLEAR_FAULTS = 3'h4;
  localparam logic [2:0] CMD_WRITE_READ_FAULTS = 3'h6;
  localparam logic [2:0] CMD_WRITE_SETTINGS = 3'h7;
  // ----------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETTINGS_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'hdf;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;
  localparam int LOAD_PROBE_OFF_BIT = 4;
  localparam int SPI_INPUT_SELECT_BIT = 3;
  localparam int SPI_OUTPUT_ON_BIT = 2;
  localparam int SPI_ROTATION_SENSE_BIT = 1;
  localparam int SPI_DUTY_LEVEL_BIT = 0;
  // Fault codes of the low nibble.
  localparam logic [3:0] CODE_NONE = 4'hf;
  localparam logic [3:0] CODE_LOAD_MISSING = 4'hc;
  localparam logic [3:0] CODE_SUPPLY_LOW = 4'h3;
  // Revision word: fixed upper nibble 0010, revision in the low nibble.
  localparam logic [3:0] VERSION_HIGH = 4'h2;
  // Consecutive duty pulses before open load is set or cleared.
  localparam logic [2:0] LOAD_PULSES = 3'h5;
endpackage

// File: hdl/hbridge_spi_diag_control.sv
/*
  Serial control and diagnosis port of one H-bridge: an 8-bit serial
  slave on its own shift clock, a settings register, the fault report
  and the fault indicator on the serial output.
  Assumes analog detectors deliver levels on clk that are already
  synchronous, and that the shift clock only runs inside frames.
*/
// Behaviour
// - Frame spans select low to select high.
// - Sample input on falling, shift on rising.
// - Eight-bit words, most significant first.
// - Each select low period is one frame.
// - Fault indicator drives output before first clock.
// - Indicator high whenever output stages tristated.
// - Indicator ORed with the serial input.
// - Decode top bits for the three reads.
// - Write commands load settings, select answer.
// - Clear command resets faults, answers faults.
// - First answer after power-up is version.
// - Unknown patterns answer with fault report.
// - Settings reset zero, command bits, probe off.
// - Serial select only with idle pins, cleared on change.
// - Serial select substitutes enable, direction, duty.
// - Fault bits: enabled, overtemp, current limiting.
// - Bit five of fault report reads zero.
// - Low nibble carries coded fault state.
// - Shorts latch; open load, undervoltage follow live.
// - Fault report reset by power, toggle, command.
// - Direction change clears limit and open load.
// - Open load clears after five freewheeling pulses.
// - Open load set after five unfreewheeled pulses.
// - After a short, outputs stay off until cleared.
`timescale 1ns/100ps
`default_nettype none
module hbridge_spi_diag_control #(
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shift_clk,
  input wire logic frame_select_low,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic bridge_off_pin,
  input wire logic duty_input,
  input wire logic rotation_sense,
  input wire logic supply_low,
  input wire logic overtemp,
  input wire logic current_limit,
  input wire logic out1_ground_short,
  input wire logic out1_battery_short,
  input wire logic out2_ground_short,
  input wire logic out2_battery_short,
  input wire logic load_open_off,
  input wire logic duty_pulse,
  input wire logic freewheel_seen,
  output logic bridge_enable,
  output logic bridge_direction,
  output logic bridge_duty,
  output logic probe_connect,
  output logic fault_indicator
);
  // ----------------------------------------------------------------
  // Link side: shift register on the shift clock
  // ----------------------------------------------------------------
  logic [7:0] shiftIn_q;
  logic [7:0] shiftOut_q;
  logic rising_q;
  logic [7:0] answerLink;
  logic faultLink_q;

  // The received word is kept after select rises, so the core can take it
  // once the select edge has crossed into clk; no clock runs between frames.
  always_ff @(negedge shift_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn_q <= 8'h00;
    end else begin
      shiftIn_q <= {shiftIn_q[6:0], serial_in};
    end
  end

  always_ff @(posedge shift_clk or posedge frame_select_low or negedge reset_n) begin
    if (!reset_n) begin
      rising_q <= 1'b0;
    end else if (frame_select_low) begin
      rising_q <= 1'b0;
    end else begin
      rising_q <= 1'b1;
    end
  end

  // Answer word crosses as a quasi-static bus: it is only changed by the
  // core between frames, so the capture at the first edge is stable.
  always_ff @(posedge shift_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_q <= 8'h00;
    end else if (!rising_q) begin
      shiftOut_q <= answerLink;
    end else begin
      shiftOut_q <= {shiftOut_q[6:0], shiftIn_q[0]};
    end
  end

  // Output is a combinational mux because the indicator must appear with
  // no clock at all; this is the one output not taken from a flip-flop.
  always_comb begin
    if (!rising_q) begin
      serial_out = faultLink_q | serial_in;
    end else begin
      serial_out = shiftOut_q[7];
    end
  end

  // ----------------------------------------------------------------
  // Crossing into clk: select synchronised over three flops
  // ----------------------------------------------------------------
  logic [2:0] selSync_q;
  logic selStable_q;
  logic frameEnd;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selSync_q <= 3'h7;
      selStable_q <= 1'b1;
    end else begin
      selSync_q <= {selSync_q[1:0], frame_select_low};
      if (selSync_q[1] == selSync_q[2]) begin
        selStable_q <= selSync_q[2];
      end
    end
  end

  assign frameEnd = (selSync_q[1] == selSync_q[2]) && selSync_q[2] && !selStable_q;

  // The received byte is stable once select is high again.
  logic [7:0] cmdByte;
  assign cmdByte = shiftIn_q;

  // ----------------------------------------------------------------
  // Core: settings register and command decode
  // ----------------------------------------------------------------
  logic [7:0] settings_q;
  logic [7:0] faultReg;
  logic [7:0] answer_q;
  logic firstAnswer_q;
  logic pinsIdle;
  logic [2:0] pinSync1_q, pinSync2_q, pinSync3_q;
  logic pinsChanged;
  logic [2:0] pinState_q;
  logic [2:0] cmdTop;
  logic isWrite;
  logic clearCmd;

  assign cmdTop = cmdByte[hbridge_spi_pkg::CMD_MSB:hbridge_spi_pkg::CMD_LSB];
  assign isWrite = (cmdTop == hbridge_spi_pkg::CMD_WRITE_SETTINGS) ||
                   (cmdTop == hbridge_spi_pkg::CMD_WRITE_READ_FAULTS);
  assign clearCmd = frameEnd && (cmdTop == hbridge_spi_pkg::CMD_CLEAR_FAULTS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1_q <= 3'h0;
      pinSync2_q <= 3'h0;
      pinSync3_q <= 3'h0;
    end else begin
      pinSync1_q <= {bridge_off_pin, duty_input, rotation_sense};
      pinSync2_q <= pinSync1_q;
      pinSync3_q <= pinSync2_q;
    end
  end
  assign pinsIdle = (pinSync3_q == 3'h0) && (pinSync2_q == 3'h0);
  assign pinsChanged = (pinSync2_q == pinSync3_q) && (pinSync3_q != pinState_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinState_q <= 3'h0;
    end else if (pinSync2_q == pinSync3_q) begin
      pinState_q <= pinSync3_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settings_q <= hbridge_spi_pkg::SETTINGS_RESET;
    end else begin
      if (frameEnd && isWrite) begin
        settings_q[7:4] <= {cmdTop, cmdByte[4]};
        settings_q[2:0] <= cmdByte[2:0];
        settings_q[3] <= cmdByte[3] && pinsIdle && !pinsChanged;
      end else if (frameEnd) begin
        settings_q[7:5] <= cmdTop;
      end
      if (pinsChanged) begin
        settings_q[3] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bridge control and fault state
  // ----------------------------------------------------------------
  logic spiSel;
  logic enableNow;
  logic dirNow;
  logic enablePrev_q;
  logic dirPrev_q;
  logic toggleClear;
  logic dirChange;
  logic anyShort;
  logic [3:0] shorts_q;
  logic loadMissing_q;
  logic [2:0] failCount_q;
  logic [2:0] okCount_q;
  logic limitSeen_q;

  assign spiSel = settings_q[hbridge_spi_pkg::SPI_INPUT_SELECT_BIT];
  assign enableNow = spiSel ? settings_q[hbridge_spi_pkg::SPI_OUTPUT_ON_BIT]
                            : !pinState_q[2];
  assign dirNow = spiSel ? settings_q[hbridge_spi_pkg::SPI_ROTATION_SENSE_BIT]
                         : pinState_q[0];
  assign toggleClear = enableNow && !enablePrev_q;
  assign dirChange = dirNow != dirPrev_q;
  assign anyShort = |shorts_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enablePrev_q <= 1'b0;
      dirPrev_q <= 1'b0;
    end else begin
      enablePrev_q <= enableNow;
      dirPrev_q <= dirNow;
    end
  end

  // Shorts latch; supply low acts like power-up clear. A new short in a
  // toggle or command clearing cycle wins over the clear; supply low always clears.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shorts_q <= 4'h0;
    end else begin
      if (toggleClear || clearCmd || supply_low) begin
        shorts_q <= 4'h0;
      end
      if (enableNow && !supply_low) begin
        shorts_q <= shorts_q & ~{4{toggleClear || clearCmd}} |
          {out2_battery_short, out2_ground_short, out1_battery_short,
           out1_ground_short};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      failCount_q <= 3'h0;
      okCount_q <= 3'h0;
      loadMissing_q <= 1'b0;
    end else if (dirChange || toggleClear || clearCmd || !enableNow) begin
      failCount_q <= 3'h0;
      okCount_q <= 3'h0;
      loadMissing_q <= 1'b0;
    end else if (duty_pulse) begin
      if (freewheel_seen) begin
        failCount_q <= 3'h0;
        if (okCount_q < hbridge_spi_pkg::LOAD_PULSES) begin
          okCount_q <= okCount_q + 3'h1;
        end
        if (okCount_q + 3'h1 >= hbridge_spi_pkg::LOAD_PULSES) begin
          loadMissing_q <= 1'b0;
        end
      end else begin
        okCount_q <= 3'h0;
        if (failCount_q < hbridge_spi_pkg::LOAD_PULSES) begin
          failCount_q <= failCount_q + 3'h1;
        end
        if (failCount_q + 3'h1 >= hbridge_spi_pkg::LOAD_PULSES) begin
          loadMissing_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limitSeen_q <= 1'b0;
    end else if (dirChange || toggleClear || clearCmd) begin
      limitSeen_q <= current_limit;
    end else if (current_limit) begin
      limitSeen_q <= 1'b1;
    end
  end

  function automatic logic [3:0] fault_code(input logic [3:0] s, input logic uv,
                                            input logic ol);
    logic [3:0] c;
    c = hbridge_spi_pkg::CODE_NONE;
    if (s[0]) c[0] = 1'b0;
    if (s[1]) c[1] = 1'b0;
    if (s[2]) c[2] = 1'b0;
    if (s[3]) c[3] = 1'b0;
    if (uv) begin
      c = hbridge_spi_pkg::CODE_SUPPLY_LOW;
    end else if (s == 4'h0 && ol) begin
      c = hbridge_spi_pkg::CODE_LOAD_MISSING;
    end
    return c;
  endfunction

  logic loadReport;
  assign loadReport = !settings_q[hbridge_spi_pkg::LOAD_PROBE_OFF_BIT] &&
                      (loadMissing_q || (!enableNow && load_open_off));

  assign faultReg = {!pinState_q[2], !overtemp, 1'b0, !limitSeen_q,
                     fault_code(shorts_q, supply_low, loadReport)};

  // ----------------------------------------------------------------
  // Answer selection for the next frame
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      firstAnswer_q <= 1'b1;
      answer_q <= 8'h00;
    end else if (firstAnswer_q) begin
      answer_q <= {hbridge_spi_pkg::VERSION_HIGH, REVISION};
      if (frameEnd) begin
        firstAnswer_q <= 1'b0;
      end
    end else if (!selStable_q || !selSync_q[1]) begin
      // Frozen while a frame is seen, so the link takes a quiet word.
      answer_q <= answer_q;
    end else begin
      unique case (settings_q[7:5])
        hbridge_spi_pkg::CMD_READ_VERSION:
          answer_q <= {hbridge_spi_pkg::VERSION_HIGH, REVISION};
        hbridge_spi_pkg::CMD_READ_SETTINGS,
        hbridge_spi_pkg::CMD_WRITE_SETTINGS: answer_q <= settings_q;
        default: answer_q <= faultReg;
      endcase
    end
  end
  assign answerLink = answer_q;

  // ----------------------------------------------------------------
  // Bridge outputs and indicator
  // ----------------------------------------------------------------
  logic stagesOff;
  assign stagesOff = !enableNow || anyShort || overtemp || supply_low;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_enable <= 1'b0;
      bridge_direction <= 1'b0;
      bridge_duty <= 1'b0;
      probe_connect <= 1'b0;
      fault_indicator <= 1'b1;
      faultLink_q <= 1'b1;
    end else begin
      bridge_enable <= !stagesOff;
      bridge_direction <= dirNow;
      bridge_duty <= spiSel ? settings_q[hbridge_spi_pkg::SPI_DUTY_LEVEL_BIT]
                            : pinState_q[1];
      probe_connect <= !enableNow &&
                       !settings_q[hbridge_spi_pkg::LOAD_PROBE_OFF_BIT];
      fault_indicator <= stagesOff;
      faultLink_q <= stagesOff;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  indicator_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    stagesOff |=> fault_indicator) else $error("indicator low while stages off");
  bit_five_a: assert property (@(posedge clk) disable iff (!reset_n)
    faultReg[5] == 1'b0) else $error("fault bit five not zero");
  short_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
    anyShort && !toggleClear && !clearCmd && !supply_low |=> anyShort)
    else $error("short code dropped without clear");
  select_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    pinsChanged |=> !spiSel) else $error("serial select survived pin change");
  short_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    anyShort |=> !bridge_enable) else $error("bridge on after short");
  clear_cmd_a: assert property (@(posedge clk) disable iff (!reset_n)
    clearCmd && !out1_ground_short && !out1_battery_short && !out2_ground_short &&
    !out2_battery_short |=> !anyShort) else $error("short kept after clear command");
endmodule
`default_nettype wire

// File: bench/spi_host_model.sv
/*
  Host-side serial master model: frame select, shift clock, data in.
  Assumes the device samples data in on falling and shifts on rising.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output var logic shift_clk,
  output var logic frame_select_low,
  output var logic serial_in,
  input wire logic serial_out
);
  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  initial begin
    shift_clk = 1'b0;
    frame_select_low = 1'b1;
    serial_in = 1'b0;
  end
  // The clock stands still between frames, as a real host's does.
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx,
      output logic pre);
    rx = 16'h0000;
    #1.3 frame_select_low = 1'b0;
    serial_in = tx[n-1];
    #2 pre = serial_out;
    // Data moves a quarter period (1.5 ns) after the falling edge, never in its step.
    for (int i = n - 1; i >= 0; i--) begin
      #1.5 serial_in = tx[i];
      #1.5 shift_clk = 1'b1;
      #3 shift_clk = 1'b0;
      rx[i] = serial_out;
    end
    #3 frame_select_low = 1'b1;
    // A released line must not keep its last level.
    serial_in = ~serial_in;
  endtask
endmodule
`default_nettype wire

// File: bench/hbridge_spi_diag_control_bench.sv
/*
  Self-checking bench of the serial control and diagnosis port.
  Assumes the host model in spi_host_model and the design package.
*/
`timescale 1ns/100ps
`default_nettype none
module hbridge_spi_diag_control_bench;
  localparam logic [3:0] REV = 4'h9; // Arbitrary value.
  logic clk, reset_n, shiftClk, selectLow, serialIn, serialOut, pre, preCmd;
  logic offPin, dutyIn, rotSense, supplyLow, overTemp, curLimit;
  logic loadOpen, dutyPulse, freewheel;
  logic bridgeEn, bridgeDir, bridgeDuty, probeOn, faultInd;
  logic [3:0] shorts;
  logic [15:0] resp;
  logic [7:0] c, x, setLow;
  logic [7:0] pats [8] = '{8'h1, 8'h2, 8'h4, 8'h8, 8'h5, 8'h6, 8'h9, 8'ha};
  logic [3:0] codes [8] = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h9, 4'h6, 4'h5};
  wire logic [7:0] outs;
  int failures, totalChecks;
  assign outs = {3'h0, bridgeEn, bridgeDir, bridgeDuty, probeOn, faultInd};
  hbridge_spi_diag_control #(.REVISION(REV)) u_dut (.clk(clk), .reset_n(reset_n),
    .shift_clk(shiftClk), .frame_select_low(selectLow), .serial_in(serialIn),
    .serial_out(serialOut), .bridge_off_pin(offPin), .duty_input(dutyIn),
    .rotation_sense(rotSense), .supply_low(supplyLow), .overtemp(overTemp),
    .current_limit(curLimit), .out1_ground_short(shorts[0]),
    .out1_battery_short(shorts[1]), .out2_ground_short(shorts[2]),
    .out2_battery_short(shorts[3]), .load_open_off(loadOpen), .duty_pulse(dutyPulse),
    .freewheel_seen(freewheel), .bridge_enable(bridgeEn), .bridge_direction(bridgeDir),
    .bridge_duty(bridgeDuty), .probe_connect(probeOn), .fault_indicator(faultInd));
  spi_host_model u_host (.shift_clk(shiftClk), .frame_select_low(selectLow),
    .serial_in(serialIn), .serial_out(serialOut));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, exp, mask, input string msg);
    totalChecks++;
    if ((got & mask) !== (exp & mask)) begin
      failures++;
      $display("FAIL at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Frames are spaced well beyond the select-high gap the port needs.
  task automatic frame(input logic [7:0] cmd);
    u_host.xfer(8, {8'h00, cmd}, resp, pre);
    tick(8);
  endtask
  task automatic ask(input logic [7:0] cmd);
    frame(cmd);
    preCmd = pre;
    frame(8'h00);
  endtask
  task automatic pulses(input int n, input logic fw);
    repeat (n) begin
      @(posedge clk) dutyPulse <= 1'b1;
      freewheel <= fw;
      @(posedge clk) dutyPulse <= 1'b0;
      tick(3);
    end
  endtask
  function automatic logic [7:0] answer(input logic [7:0] cmd, flt, lowSet);
    case (cmd[7:5])
      3'h1: return {4'h2, REV};
      3'h3, 3'h7: return lowSet;
      default: return flt;
    endcase
  endfunction
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    #900000;
    failures++;
    $display("FAIL at %0t: run hung", $time);
    finish_test;
  end
  initial begin
    {clk, offPin, dutyIn, rotSense, supplyLow, overTemp, curLimit} = '0;
    {loadOpen, dutyPulse, freewheel, shorts, setLow} = '0;
    // Reset falls after time zero so every asynchronous reset sees its edge.
    reset_n = 1'b1;
    #1 reset_n = 1'b0;
    void'($urandom(47));
    tick(12);
    reset_n <= 1'b1;
    tick(4);
    frame(8'h00);
    check(resp[7:0], {4'h2, REV}, 8'hff, "first answer");
    check({7'h0, pre}, 8'h00, 8'h01, "idle flag");
    check(outs, 8'h10, 8'h11, "pin mode out");
    for (int p = 0; p < 8; p++) begin
      // Serial select and output enable stay clear so no toggle clear occurs.
      c = {p[2:0], 5'($urandom()) & 5'h13};
      if (p >= 6) setLow = {3'h0, c[4:0]};
      ask(c);
      check(resp[7:0], answer(c, 8'hdf, setLow), (p == 3 || p == 7) ? 8'h1f : 8'hff,
        "command answer");
      check({7'h0, preCmd}, {7'h0, c[7]}, 8'h01, "flag or input");
    end
    x = 8'($urandom());
    u_host.xfer(16, {x, 8'h00}, resp, pre);
    tick(8);
    check(resp[7:0], x, 8'hff, "chain delay");
    check(resp[15:8], 8'hdf, 8'hff, "chain own word");
    frame(8'he0);
    $display("test commands done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) shorts <= pats[k][3:0];
      tick(3);
      @(posedge clk) shorts <= 4'h0;
      ask(8'h00);
      check(resp[7:0], {4'h0, codes[k]}, 8'h2f, "short code");
      check(outs, 8'h01, 8'h11, "short off");
      check({7'h0, preCmd}, 8'h01, 8'h01, "flag set");
      if (k[0]) begin
        frame(8'h80);
      end else begin
        @(posedge clk) offPin <= 1'b1;
        tick(10);
        @(posedge clk) offPin <= 1'b0;
        tick(10);
      end
      ask(8'h00);
      check(resp[7:0], 8'hdf, 8'hff, "cleared");
      check(outs, 8'h10, 8'h11, "back on");
    end
    @(posedge clk) supplyLow <= 1'b1;
    ask(8'h00);
    check(resp[7:0], 8'h03, 8'h2f, "supply low");
    @(posedge clk) supplyLow <= 1'b0;
    ask(8'h00);
    check(resp[7:0], 8'h0f, 8'h0f, "supply back");
    $display("test faults done");
    @(posedge clk) dutyIn <= 1'b1;
    pulses(4, 1'b0);
    ask(8'h00);
    check(resp[7:0], 8'h0f, 8'h0f, "four pulses");
    pulses(1, 1'b0);
    ask(8'h00);
    check(resp[7:0], 8'h0c, 8'h0f, "open load");
    pulses(4, 1'b1);
    ask(8'h00);
    check(resp[7:0], 8'h0c, 8'h0f, "four freewheel");
    pulses(1, 1'b1);
    ask(8'h00);
    check(resp[7:0], 8'h0f, 8'h0f, "load back");
    pulses(5, 1'b0);
    @(posedge clk) curLimit <= 1'b1;
    ask(8'h00);
    check(resp[7:0], 8'h0c, 8'h1f, "limit shown");
    @(posedge clk) curLimit <= 1'b0;
    @(posedge clk) rotSense <= 1'b1;
    ask(8'h00);
    check(resp[7:0], 8'h1f, 8'h1f, "dir clears");
    ask(8'hef);
    ask(8'h60);
    check(resp[7:0], 8'h00, 8'h08, "select refused");
    {rotSense, dutyIn} <= 2'b00;
    tick(10);
    ask(8'hef);
    check(outs, 8'h1c, 8'h1d, "serial drive");
    ask(8'hea);
    check(outs, 8'h09, 8'h1d, "serial off");
    @(posedge clk) rotSense <= 1'b1;
    tick(10);
    check(outs, 8'h18, 8'h1d, "pin takes over");
    ask(8'h60);
    check(resp[7:0], 8'h02, 8'h1f, "select cleared");
    $display("test control done");
    {offPin, loadOpen} <= 2'b11;
    tick(10);
    ask(8'h00);
    check(resp[7:0], 8'h0c, 8'ha7, "off state");
    check(outs, 8'h03, 8'h13, "probe on");
    ask(8'hf0);
    ask(8'h00);
    check(resp[7:0], 8'h0f, 8'h0f, "probe off");
    check(outs, 8'h00, 8'h02, "probe off pin");
    {offPin, loadOpen} <= 2'b00;
    @(posedge clk) overTemp <= 1'b1;
    ask(8'h00);
    check(resp[7:0], 8'h00, 8'h60, "overtemp");
    check(outs, 8'h01, 8'h01, "overtemp flag");
    $display("test pins done");
    finish_test;
  end
endmodule
`default_nettype wire
